// >>> bwtt_defines.vh
// Constants for the byte/word transfer timing block
`ifndef BWTT_DEFINES_VH
`define BWTT_DEFINES_VH
`define BWTT_REG_ROM 3'h0
`define BWTT_REG_FAST_RAM 3'h1
`define BWTT_REG_PERI_RAM 3'h2
`define BWTT_REG_SFR 3'h3
`define BWTT_REG_EXT_MEM 3'h4
`define BWTT_REG_BAD 3'h7
`define BWTT_SADDR_LO 16'hfe20
`define BWTT_SADDR_HI 16'hff1f
`define BWTT_SADDRP_HI 16'hff1e
`define BWTT_HIGH_AREA 16'hfe00
`define BWTT_OP_BYTE_XFER 4'h0
`define BWTT_OP_BYTE_SWAP 4'h1
`define BWTT_OP_WORD_LOAD 4'h2
`define BWTT_OP_WORD_STORE 4'h3
`define BWTT_OP_WORD_SWAP 4'h4
`define BWTT_OP_ALU_READ 4'h5
`define BWTT_OP_ALU_WRITE 4'h6
`define BWTT_OP_COMPARE 4'h7
`define BWTT_OP_FLAGS_IMM 4'h8
`define BWTT_OP_FLAGS_ACC 4'h9
`define BWTT_OP_STBY_WDOG 4'ha
`define BWTT_OP_SFR_XFER 4'hb
`define BWTT_ADDR_WA 2'h0
`define BWTT_ADDR_BI 2'h1
`define BWTT_ADDR_PD 2'h2
`define BWTT_ADDR_ST 2'h3
`define BWTT_RA_OP 2'h0
`define BWTT_RA_MODE 2'h1
`define BWTT_RA_ADDR 2'h2
`define BWTT_RA_STAT 2'h3
`define BWTT_RST_WAIT 4'h0
`define BWTT_FLAGS_W 5
`define BWTT_DEDICATED_CYC 8'h0d
`endif

// >>> bwtt_cycle_table.v
// Cycle count lookup per form, region, fetch mode and wait count
`timescale 1ns/100ps
`include "bwtt_defines.vh"
module bwtt_cycle_table (
    input wire [3:0] op,
    input wire [1:0] amode,
    input wire [2:0] region,
    input wire fast_fetch,
    input wire [3:0] wait_cnt,
    output reg [7:0] cycles,
    output reg illegal
);
    reg [7:0] rom;
    reg [7:0] fast_ram;
    reg [7:0] peri_ram;
    reg [7:0] sfr;
    reg [7:0] ext_mem;
    reg [7:0] nbase;
    reg [7:0] nram;
    reg [2:0] wmul;
    reg no_rom;
    always @* begin
        rom = 8'h00;
        fast_ram = 8'h00;
        peri_ram = 8'h00;
        sfr = 8'h00;
        ext_mem = 8'h00;
        nbase = 8'h00;
        nram = 8'h00;
        wmul = 3'h0;
        no_rom = 1'b0;
        case (op)
            `BWTT_OP_WORD_LOAD: begin
                rom = 8'h10; fast_ram = 8'h08; peri_ram = 8'h10; sfr = 8'h0a; ext_mem = 8'h10;
                nbase = 8'h0e; nram = 8'h0e; wmul = 3'h2;
            end
            `BWTT_OP_WORD_STORE: begin
                no_rom = 1'b1;
                rom = 8'h00; fast_ram = 8'h09; peri_ram = 8'h11; sfr = 8'h0b; ext_mem = 8'h11;
                nbase = 8'h0f; nram = 8'h0f; wmul = 3'h2;
            end
            `BWTT_OP_WORD_SWAP: begin
                no_rom = 1'b1;
                rom = 8'h00; fast_ram = 8'h0d; peri_ram = 8'h1d; sfr = 8'h11; ext_mem = 8'h1d;
                nbase = 8'h19; nram = 8'h19; wmul = 3'h4;
            end
            `BWTT_OP_BYTE_SWAP: begin
                no_rom = 1'b1;
                rom = 8'h00; fast_ram = 8'h0d; peri_ram = 8'h13; sfr = 8'h11; ext_mem = 8'h13;
                nbase = 8'h11; nram = 8'h11; wmul = 3'h2;
            end
            `BWTT_OP_ALU_READ: begin
                rom = 8'h0c; fast_ram = 8'h09; peri_ram = 8'h0c; sfr = 8'h0b; ext_mem = 8'h0c;
                nbase = 8'h0b; nram = 8'h0b; wmul = 3'h1;
            end
            `BWTT_OP_ALU_WRITE: begin
                no_rom = 1'b1;
                rom = 8'h00; fast_ram = 8'h0b; peri_ram = 8'h11; sfr = 8'h0f; ext_mem = 8'h11;
                nbase = 8'h0f; nram = 8'h0f; wmul = 3'h2;
            end
            `BWTT_OP_COMPARE: begin
                rom = 8'h0b; fast_ram = 8'h08; peri_ram = 8'h0b; sfr = 8'h0a; ext_mem = 8'h0b;
                nbase = 8'h0a; nram = 8'h0a; wmul = 3'h1;
            end
            `BWTT_OP_BYTE_XFER, `BWTT_OP_FLAGS_IMM, `BWTT_OP_FLAGS_ACC, `BWTT_OP_SFR_XFER: begin
                rom = 8'h09; fast_ram = 8'h06; peri_ram = 8'h09; sfr = 8'h08; ext_mem = 8'h09;
                nbase = 8'h08; nram = 8'h08; wmul = 3'h1;
            end
            default: begin
                rom = `BWTT_DEDICATED_CYC; fast_ram = `BWTT_DEDICATED_CYC; peri_ram = `BWTT_DEDICATED_CYC;
                sfr = `BWTT_DEDICATED_CYC; ext_mem = `BWTT_DEDICATED_CYC;
                nbase = `BWTT_DEDICATED_CYC; nram = `BWTT_DEDICATED_CYC; wmul = 3'h0;
            end
        endcase
        illegal = (region == `BWTT_REG_BAD) || (no_rom && region == `BWTT_REG_ROM);
        if (fast_fetch) begin
            case (region)
                `BWTT_REG_ROM: cycles = rom;
                `BWTT_REG_FAST_RAM: cycles = fast_ram;
                `BWTT_REG_PERI_RAM: cycles = peri_ram;
                `BWTT_REG_SFR: cycles = sfr;
                default: cycles = ext_mem;
            endcase
        end else begin
            case (region)
                `BWTT_REG_FAST_RAM: cycles = fast_ram;
                `BWTT_REG_PERI_RAM: cycles = nram;
                `BWTT_REG_SFR: cycles = sfr;
                default: cycles = nbase + {1'b0, wmul[2:0] * {3'h0, wait_cnt}} ;
            endcase
        end
    end
endmodule // bwtt_cycle_table

// >>> bwtt_exec_seq.v
// Execution sequencer for byte/word transfer, swap and 8-bit ALU memory forms
// How it works
// - Byte transfer copies source into destination, source unchanged.
// - Immediate or accumulator write to low flags loads all five flags.
// - Writes to interrupt control or status word block interrupt one extra instruction.
// - Standby or watchdog destination uses its own dedicated opcode.
// - Byte swap exchanges both operands, flags untouched.
// - Short direct byte FE20-FF1F; short word FE20-FF1E, even only.
// - Word operands any address below FE00, even only at FE00-FFFF.
// - Normal fetch adds wait count per ROM/external access, once, twice or four times.
// - Base-index word load 16/8/16/10/16 fast, 14+2W/8/14/10/14+2W normal.
// - Displaced word swap 13/29/17/29 fast, 25+4W external normal, no ROM.
// - Indexed byte swap 13/19 fast, 17+2W external normal, no ROM.
// - Stepping-pointer ALU read 12/9/12/11/12 fast, 11+w normal.
// - Displaced ALU memory write 11/17 fast, 15+2W normal, no ROM.
// - Compare allowed on ROM, 11/8/11/10/11 fast, 10+w normal.
// - Stepping word store 9/17/11 fast, 15+2W external normal, no ROM.
`timescale 1ns/100ps
`include "bwtt_defines.vh"
module bwtt_exec_seq #(
    parameter PERI_RAM_BASE = 16'hf000,
    parameter FAST_RAM_BASE = 16'hfe00,
    parameter SFR_BASE = 16'hff00,
    parameter ROM_TOP = 16'h7fff
) (
    input wire CORE_CLK,
    input wire SYS_RST,
    input wire CLK_EN,
    input wire [1:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [15:0] REG_RDATA,
    input wire START,
    input wire [7:0] SRC_DATA,
    input wire [7:0] DST_DATA,
    input wire IRQ_PENDING,
    output reg BUSY,
    output reg DONE,
    output reg ADDR_FAULT,
    output reg [7:0] DST_OUT,
    output reg [7:0] SRC_OUT,
    output reg DST_WE,
    output reg SRC_WE,
    output reg [4:0] FLAGS_LOW,
    output reg IRQ_ACK
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_DONE = 2'h2;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [3:0] op_reg;
    reg [1:0] amode_reg;
    reg word_reg;
    reg short_reg;
    reg icr_reg;
    reg fast_reg;
    reg [3:0] wait_reg;
    reg [15:0] addr_reg;
    reg [7:0] count_reg;
    reg [1:0] irq_hold_reg;
    reg [2:0] region;
    reg range_bad;
    wire [7:0] cycles;
    wire illegal;
    always @* begin
        range_bad = 1'b0;
        if (short_reg) begin
            range_bad = (addr_reg < `BWTT_SADDR_LO) || (addr_reg > (word_reg ? `BWTT_SADDRP_HI : `BWTT_SADDR_HI))
                || (word_reg && addr_reg[0]);
        end else if (word_reg && addr_reg >= `BWTT_HIGH_AREA && addr_reg[0]) begin
            range_bad = 1'b1;
        end
        if (range_bad) begin
            region = `BWTT_REG_BAD;
        end else if (addr_reg >= SFR_BASE) begin
            region = `BWTT_REG_SFR;
        end else if (addr_reg >= FAST_RAM_BASE) begin
            region = `BWTT_REG_FAST_RAM;
        end else if (addr_reg >= PERI_RAM_BASE) begin
            region = `BWTT_REG_PERI_RAM;
        end else if (addr_reg <= ROM_TOP) begin
            region = `BWTT_REG_ROM;
        end else begin
            region = `BWTT_REG_EXT_MEM;
        end
    end
    bwtt_cycle_table u_table (
        .op(op_reg),
        .amode(amode_reg),
        .region(region),
        .fast_fetch(fast_reg),
        .wait_cnt(wait_reg),
        .cycles(cycles),
        .illegal(illegal)
    );
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (START) state_next = ST_RUN;
            // Count is still zero in the first run cycle, so only a count of one or an illegal access ends it
            ST_RUN: if (illegal || count_reg == 8'h01) state_next = ST_DONE;
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end
    always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= ST_IDLE;
            op_reg <= `BWTT_OP_BYTE_XFER;
            amode_reg <= `BWTT_ADDR_WA;
            word_reg <= 1'b0;
            short_reg <= 1'b0;
            icr_reg <= 1'b0;
            fast_reg <= 1'b1;
            wait_reg <= `BWTT_RST_WAIT;
            addr_reg <= 16'h0000;
            count_reg <= 8'h00;
            irq_hold_reg <= 2'h0;
            REG_RDATA <= 16'h0000;
            BUSY <= 1'b0;
            DONE <= 1'b0;
            ADDR_FAULT <= 1'b0;
            DST_OUT <= 8'h00;
            SRC_OUT <= 8'h00;
            DST_WE <= 1'b0;
            SRC_WE <= 1'b0;
            FLAGS_LOW <= 5'h00;
            IRQ_ACK <= 1'b0;
        end else if (CLK_EN) begin
            state_reg <= state_next;
            DONE <= 1'b0;
            DST_WE <= 1'b0;
            SRC_WE <= 1'b0;
            IRQ_ACK <= 1'b0;
            if (REG_WR && state_reg == ST_IDLE) begin
                case (REG_ADDR)
                    `BWTT_RA_OP: begin
                        op_reg <= REG_WDATA[3:0];
                        amode_reg <= REG_WDATA[5:4];
                        word_reg <= REG_WDATA[6];
                        short_reg <= REG_WDATA[7];
                        icr_reg <= REG_WDATA[8];
                    end
                    `BWTT_RA_MODE: begin
                        fast_reg <= REG_WDATA[0];
                        wait_reg <= REG_WDATA[7:4];
                    end
                    `BWTT_RA_ADDR: addr_reg <= REG_WDATA;
                    default: ;
                endcase
            end
            if (REG_RD) begin
                case (REG_ADDR)
                    `BWTT_RA_OP: REG_RDATA <= {7'h00, icr_reg, short_reg, word_reg, amode_reg, op_reg};
                    `BWTT_RA_MODE: REG_RDATA <= {8'h00, wait_reg, 3'h0, fast_reg};
                    `BWTT_RA_ADDR: REG_RDATA <= addr_reg;
                    default: REG_RDATA <= {3'h0, FLAGS_LOW, 5'h00, region};
                endcase
            end else begin
                REG_RDATA <= 16'h0000;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (START) begin
                        BUSY <= 1'b1;
                        ADDR_FAULT <= 1'b0;
                        count_reg <= 8'h00;
                    end else if (IRQ_PENDING && irq_hold_reg == 2'h0) begin
                        IRQ_ACK <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (count_reg == 8'h00) begin
                        count_reg <= cycles;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                    if (illegal) begin
                        ADDR_FAULT <= 1'b1;
                    end
                end
                ST_DONE: begin
                    BUSY <= 1'b0;
                    DONE <= 1'b1;
                    if (!ADDR_FAULT) begin
                        case (op_reg)
                            `BWTT_OP_BYTE_SWAP, `BWTT_OP_WORD_SWAP: begin
                                DST_OUT <= SRC_DATA;
                                SRC_OUT <= DST_DATA;
                                DST_WE <= 1'b1;
                                SRC_WE <= 1'b1;
                            end
                            `BWTT_OP_FLAGS_IMM, `BWTT_OP_FLAGS_ACC: begin
                                FLAGS_LOW <= SRC_DATA[4:0];
                                DST_OUT <= SRC_DATA;
                                DST_WE <= 1'b1;
                            end
                            `BWTT_OP_ALU_READ, `BWTT_OP_COMPARE: ;
                            default: begin
                                DST_OUT <= SRC_DATA;
                                DST_WE <= 1'b1;
                            end
                        endcase
                    end
                    if (icr_reg || op_reg == `BWTT_OP_FLAGS_IMM || op_reg == `BWTT_OP_FLAGS_ACC
                        || op_reg == `BWTT_OP_STBY_WDOG) begin
                        irq_hold_reg <= 2'h1;
                    end else if (irq_hold_reg != 2'h0) begin
                        irq_hold_reg <= irq_hold_reg - 2'h1;
                    end
                end
                default: ;
            endcase
        end
    end
endmodule // bwtt_exec_seq

// >>> bwtt_exec_seq_asserts.sv
// Port assertions for the execution sequencer
`timescale 1ns/100ps
`include "bwtt_defines.vh"
module bwtt_exec_seq_asserts (
    input wire CORE_CLK,
    input wire SYS_RST,
    input wire CLK_EN,
    input wire [1:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire REG_WR,
    input wire START,
    input wire [7:0] SRC_DATA,
    input wire [7:0] DST_DATA,
    input wire BUSY,
    input wire DONE,
    input wire ADDR_FAULT,
    input wire [7:0] DST_OUT,
    input wire [7:0] SRC_OUT,
    input wire DST_WE,
    input wire SRC_WE,
    input wire [4:0] FLAGS_LOW,
    input wire IRQ_ACK
);
    reg [3:0] op_reg;
    reg sens_reg;
    reg hold_reg;
    reg [7:0] cnt_reg;
    wire [4:0] src_low = SRC_DATA[4:0];
    wire flag_op = op_reg == `BWTT_OP_FLAGS_IMM || op_reg == `BWTT_OP_FLAGS_ACC;
    // Shadow of the op register and edges since START
    always @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            op_reg <= 4'h0;
            sens_reg <= 1'b0;
            hold_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end else if (CLK_EN) begin
            if (REG_WR && REG_ADDR == 2'h0 && !BUSY) begin
                op_reg <= REG_WDATA[3:0];
                sens_reg <= REG_WDATA[8];
            end
            if (DONE) begin
                hold_reg <= sens_reg || flag_op;
            end
            cnt_reg <= (START && !BUSY) ? 8'h01 : cnt_reg + 8'h01;
        end
    end
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST);
    a_xfer_copy: assert property (DONE && !ADDR_FAULT && op_reg == `BWTT_OP_BYTE_XFER |->
        DST_WE && !SRC_WE && DST_OUT == SRC_DATA) else $error("byte copy wrong");
    a_swap_exch: assert property (DONE && !ADDR_FAULT && op_reg == `BWTT_OP_BYTE_SWAP |->
        DST_WE && SRC_WE && DST_OUT == SRC_DATA && SRC_OUT == DST_DATA) else $error("byte swap wrong");
    a_flags_load: assert property (DONE && !ADDR_FAULT && flag_op |=> FLAGS_LOW == $past(src_low))
        else $error("flags not loaded");
    a_flags_keep: assert property (!$stable(FLAGS_LOW) |-> flag_op)
        else $error("flags changed by other form");
    a_ack_hold: assert property (IRQ_ACK |-> !BUSY && !hold_reg && !(DONE && sens_reg))
        else $error("interrupt taken too early");
    a_dedicated_time: assert property (DONE && !ADDR_FAULT && op_reg == `BWTT_OP_STBY_WDOG |->
        cnt_reg == `BWTT_DEDICATED_CYC + 8'h02 || cnt_reg == `BWTT_DEDICATED_CYC + 8'h03) else $error("standby time");
    a_fault_no_write: assert property ((DST_WE || SRC_WE) |-> DONE && !ADDR_FAULT)
        else $error("write outside done or on fault");
    a_fault_held: assert property (ADDR_FAULT && !(START && !BUSY && CLK_EN) |=> ADDR_FAULT)
        else $error("fault dropped early");
    a_busy_bound: assert property ($rose(BUSY) |-> ##[1:100] DONE)
        else $error("instruction never ends");
    a_done_pulse: assert property (DONE |-> !BUSY ##1 !DONE)
        else $error("done not a single pulse");
    c_fault: cover property (DONE && ADDR_FAULT);
    c_swap: cover property (DONE && op_reg == `BWTT_OP_BYTE_SWAP);
    c_hold: cover property (DONE && sens_reg);
endmodule // bwtt_exec_seq_asserts
bind bwtt_exec_seq bwtt_exec_seq_asserts u_bwtt_exec_seq_asserts (.CORE_CLK, .SYS_RST, .CLK_EN, .REG_ADDR,
    .REG_WDATA, .REG_WR, .START, .SRC_DATA, .DST_DATA, .BUSY, .DONE, .ADDR_FAULT, .DST_OUT, .SRC_OUT,
    .DST_WE, .SRC_WE, .FLAGS_LOW, .IRQ_ACK);

// >>> bwtt_mem_model.sv
// Operand store behind the sequencer data ports
`timescale 1ns/100ps
module bwtt_mem_model (
    input wire clk,
    input wire rst,
    input wire ld,
    input wire [7:0] ld_src,
    input wire [7:0] ld_dst,
    input wire [7:0] dst_out,
    input wire [7:0] src_out,
    input wire dst_we,
    input wire src_we,
    output reg [7:0] src_data,
    output reg [7:0] dst_data
);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            src_data <= 8'h00;
            dst_data <= 8'h00;
        end else if (ld) begin
            src_data <= ld_src;
            dst_data <= ld_dst;
        end else begin
            if (dst_we) begin
                dst_data <= dst_out;
            end
            if (src_we) begin
                src_data <= src_out;
            end
        end
    end
endmodule // bwtt_mem_model

// >>> byte_word_transfer_timing_bench.sv
// Self-checking bench for the transfer timing sequencer
`timescale 1ns/100ps
module byte_word_transfer_timing_bench;
    typedef struct {int ncyc; logic fault; logic chkd; logic swp; logic sens; logic [7:0] dv; logic [7:0] sv;} bwtt_note_t;
    reg CORE_CLK = 1'b0;
    reg SYS_RST = 1'b1;
    reg CLK_EN = 1'b1;
    reg [1:0] REG_ADDR = 2'h0;
    reg [15:0] REG_WDATA = 16'h0000;
    reg REG_WR = 1'b0;
    reg REG_RD = 1'b0;
    reg START = 1'b0;
    reg IRQ_PENDING = 1'b0;
    reg ld = 1'b0;
    reg [7:0] ld_src = 8'h00;
    reg [7:0] ld_dst = 8'h00;
    wire [15:0] REG_RDATA;
    wire [7:0] SRC_DATA, DST_DATA, DST_OUT, SRC_OUT;
    wire [4:0] FLAGS_LOW;
    wire BUSY, DONE, ADDR_FAULT, DST_WE, SRC_WE, IRQ_ACK;
    int num_errors = 0;
    int total_checks = 0;
    int seed = 32'hb7cc913d;
    int blk = 0;
    int cyc = 0;
    int i, r, m, c, w;
    logic rdp = 1'b0;
    logic a;
    logic [4:0] fl;
    logic [31:0] rr;
    bwtt_note_t n;
    bwtt_note_t iq[$];
    logic [31:0] rq[$];
    int fst_t[7][5] = '{'{16, 8, 16, 10, 16}, '{0, 13, 29, 17, 29}, '{0, 13, 19, 17, 19}, '{12, 9, 12, 11, 12},
        '{0, 11, 17, 15, 17}, '{11, 8, 11, 10, 11}, '{0, 9, 17, 11, 17}};
    int nrm_t[7][5] = '{'{14, 8, 14, 10, 14}, '{0, 13, 25, 17, 25}, '{0, 13, 17, 17, 17}, '{11, 9, 11, 11, 11},
        '{0, 11, 15, 15, 15}, '{10, 8, 10, 10, 10}, '{0, 9, 15, 11, 15}};
    int wmul[7] = '{2, 4, 2, 1, 2, 1, 2};
    logic [3:0] opc[7] = '{4'h2, 4'h4, 4'h1, 4'h5, 4'h6, 4'h7, 4'h3};
    logic [1:0] amd[7] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h2, 2'h3, 2'h3};
    logic [6:0] wdt = 7'b1000011;
    logic [15:0] adr[5] = '{16'h0100, 16'hfe40, 16'hf100, 16'hff40, 16'h9000};
    logic [22:0] sdt[8] = '{{4'h0, 16'hfe1f, 3'h3}, {4'h0, 16'hfe20, 3'h2}, {4'h0, 16'hff1f, 3'h2},
        {4'h0, 16'hff20, 3'h3}, {4'h2, 16'hff1e, 3'h6}, {4'h2, 16'hff1f, 3'h7}, {4'h2, 16'h1001, 3'h4},
        {4'h2, 16'hfe01, 3'h5}};
    bwtt_exec_seq u_bwtt_exec_seq (.CORE_CLK, .SYS_RST, .CLK_EN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
        .REG_RDATA, .START, .SRC_DATA, .DST_DATA, .IRQ_PENDING, .BUSY, .DONE, .ADDR_FAULT, .DST_OUT, .SRC_OUT,
        .DST_WE, .SRC_WE, .FLAGS_LOW, .IRQ_ACK);
    bwtt_mem_model u_bwtt_mem_model (.clk(CORE_CLK), .rst(SYS_RST), .ld, .ld_src, .ld_dst, .dst_out(DST_OUT),
        .src_out(SRC_OUT), .dst_we(DST_WE), .src_we(SRC_WE), .src_data(SRC_DATA), .dst_data(DST_DATA));
    always #5 CORE_CLK = ~CORE_CLK;
    task chk16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_cyc(input int got, input int cnt);
        total_checks++;
        if (got < cnt + 2 || got > cnt + 3) begin
            num_errors++;
            $display("mismatch at %0t: %0d edges for count %0d", $time, got, cnt);
        end
    endtask
    task tally_and_finish;
        if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wr(input logic [1:0] ad, input logic [15:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= ad;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask
    task rd(input logic [1:0] ad, input logic [15:0] e, input logic [15:0] mk);
        rq.push_back({mk, e});
        @(posedge CORE_CLK);
        REG_ADDR <= ad;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
    endtask
    task run(input logic [3:0] op, input logic [1:0] am, input logic [15:0] ad, input logic wd, input logic sd,
        input logic sens, input int cnt, input logic f);
        logic [7:0] s, d;
        int k;
        {d, s} = 16'($random(seed));
        wr(2'h0, {7'h00, sens, sd, wd, am, op});
        wr(2'h2, ad);
        @(posedge CORE_CLK);
        ld <= 1'b1;
        ld_src <= s;
        ld_dst <= d;
        @(posedge CORE_CLK);
        ld <= 1'b0;
        iq.push_back('{cnt, f, op < 4'h2, op == 4'h1, sens, d, s});
        START <= 1'b1;
        @(posedge CORE_CLK);
        START <= 1'b0;
        for (k = 0; k < 200; k++) begin
            @(posedge CORE_CLK);
            #1;
            if (DONE) break;
        end
        if (DONE !== 1'b1) begin
            num_errors++;
            tally_and_finish;
        end
    endtask
    // Result watcher: oldest note against each completion or read
    always @(posedge CORE_CLK) begin
        if (rdp) begin
            rr = rq.pop_front();
            chk16(REG_RDATA & rr[31:16], rr[15:0]);
        end
        rdp = REG_RD;
        if (blk > 0) chk16(IRQ_ACK, 16'h0000);
        if (DONE) begin
            n = iq.pop_front();
            chk16(ADDR_FAULT, n.fault);
            if (n.ncyc > 0) chk_cyc(cyc, n.ncyc);
            if (n.chkd && !n.fault) chk16({DST_WE, SRC_WE, DST_OUT}, {1'b1, n.swp, n.sv});
            if (n.swp && !n.fault) chk16(SRC_OUT, n.dv);
            blk = n.sens ? 1 : (blk > 0 ? blk - 1 : 0);
        end
        cyc = (START && !BUSY) ? 1 : cyc + 1;
    end
    initial begin
        repeat (4) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        rd(2'h1, 16'h0001, 16'hffff);
        for (m = 0; m < 2; m++) begin
            w = m ? 3 : 0;
            wr(2'h1, {8'h00, w[3:0], 3'h0, ~m[0]});
            rd(2'h1, {8'h00, w[3:0], 3'h0, ~m[0]}, 16'hffff);
            for (i = 0; i < 7; i++) for (r = 0; r < 5; r++) begin
                c = m ? nrm_t[i][r] : fst_t[i][r];
                if (m && c > 0 && (r == 0 || r == 4)) c = c + wmul[i] * w;
                run(opc[i], amd[i], adr[r], wdt[i], 1'b0, 1'b0, c, c == 0);
                if (i == 0) rd(2'h3, r[15:0], 16'h0007);
            end
        end
        wr(2'h1, 16'h0001);
        run(4'h0, 2'h0, 16'hfe40, 1'b0, 1'b0, 1'b0, 0, 1'b0);
        for (i = 8; i < 10; i++) begin
            run(i[3:0], 2'h0, 16'hfe40, 1'b0, 1'b0, 1'b0, 0, 1'b0);
            fl = ld_src[4:0];
            rd(2'h3, {3'h0, fl, 8'h00}, 16'h1f00);
            run(4'hb, 2'h0, 16'hff40, 1'b0, 1'b0, 1'b0, 0, 1'b0);
            rd(2'h3, {3'h0, fl, 8'h00}, 16'h1f00);
        end
        run(4'ha, 2'h0, 16'hff40, 1'b0, 1'b0, 1'b0, 13, 1'b0);
        for (i = 0; i < 8; i++) run(sdt[i][22:19], 2'h0, sdt[i][18:3], sdt[i][2], sdt[i][1], 1'b0, 0, sdt[i][0]);
        @(posedge CORE_CLK);
        IRQ_PENDING <= 1'b1;
        run(4'h0, 2'h0, 16'hfe40, 1'b0, 1'b0, 1'b1, 0, 1'b0);
        run(4'h1, 2'h0, 16'hfe40, 1'b0, 1'b0, 1'b0, 0, 1'b0);
        a = 1'b0;
        repeat (20) begin
            @(posedge CORE_CLK);
            #1;
            a = a | IRQ_ACK;
        end
        chk16(a, 16'h0001);
        @(posedge CORE_CLK);
        IRQ_PENDING <= 1'b0;
        @(posedge CORE_CLK);
        // Write with the clock enable low must not land
        CLK_EN <= 1'b0;
        wr(2'h1, 16'h0050);
        CLK_EN <= 1'b1;
        rd(2'h1, 16'h0001, 16'hffff);
        wr(2'h1, 16'h0050);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        rd(2'h1, 16'h0001, 16'hffff);
        rd(2'h3, 16'h0000, 16'h1f00);
        repeat (3) @(posedge CORE_CLK);
        tally_and_finish;
    end
endmodule // byte_word_transfer_timing_bench
